// File: i2c_arbitration_loss.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module i2c_arbitration_loss #(
  parameter int HALF_CYC = i2c_arb_pkg::SCL_HALF_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Open-drain bus pins
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe_n,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe_n,
  // Interrupt
  output logic             irq
);
  import i2c_arb_pkg::*;

  if (HALF_CYC < 4 || HALF_CYC > 65535) begin : g_chk
    $error("HALF_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  master_state_t    state_ff;
  master_state_t    nxt_state;
  logic [15:0]      halfCnt_ff;
  logic             timerDone;
  logic             run_ff;
  logic             eightClk_ff;
  logic             ackBit_ff;
  logic             endFlag_ff;
  logic             busy_ff;
  logic             mst_ff;
  logic             trx_ff;
  logic             ovr_ff;
  logic             al_ff;
  logic             slave_ff;
  logic             std_ff;
  logic             lost_ff;
  logic             firstByte_ff;
  logic             rxFull_ff;
  logic [7:0]       txData_ff;
  logic [7:0]       txShift_ff;
  logic [7:0]       rxShift_ff;
  logic [7:0]       rxData_ff;
  logic [3:0]       riseCnt_ff;
  logic             sdaOut_ff;
  logic             nxt_sdaOut;
  logic [IRQ_W-1:0] irqStat_ff;
  logic [IRQ_W-1:0] irqMask_ff;
  logic [IRQ_W-1:0] irqSnap_ff;
  logic [IRQ_W-1:0] irqEvents;
  logic [31:0]      prdata_ff;
  logic             sclLine;
  logic             sdaLine;
  logic             sclRise;
  logic             sclFall;
  logic             sdaFall;
  logic             startDet;
  logic             stopDet;
  logic             setupPh;
  logic             wrAcc;
  logic             rdAcc;
  logic             ctrlWr;
  logic             statWr;
  logic             startCmd;
  logic             stopCmd;
  logic             lossBusy;
  logic             lossEarly;
  logic             lossData;
  logic             anyLoss;
  logic             checkWin;
  logic             byteEnd;
  logic             endSet;
  logic             endClr;
  logic [3:0]       lastClk;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == CTRL_OFS) || (a == STAT_OFS) || (a == DATA_OFS) ||
               (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
  endfunction : isMapped

  function automatic logic bitToSend(input logic [3:0] idx, input logic tx,
                                     input logic [7:0] sh, input logic ack);
    if (idx < DATA_CLKS) begin
      bitToSend = tx ? sh[3'(4'h7 - idx)] : 1'b1;
    end else begin
      bitToSend = tx ? 1'b1 : ack;
    end
  endfunction : bitToSend

  // ----------------------------------------------------------------
  // Line monitor
  // ----------------------------------------------------------------
  arb_line_monitor u_mon (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .sclPin   (sclIn),
    .sdaPin   (sdaIn),
    .sclLine  (sclLine),
    .sdaLine  (sdaLine),
    .sclRise  (sclRise),
    .sclFall  (sclFall),
    .sdaFall  (sdaFall),
    .startDet (startDet),
    .stopDet  (stopDet)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setupPh  = psel & ~penable;
  assign wrAcc    = psel & penable & pwrite;
  assign rdAcc    = psel & penable & ~pwrite;
  assign ctrlWr   = wrAcc && (paddr == CTRL_OFS);
  assign statWr   = wrAcc && (paddr == STAT_OFS);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~isMapped(paddr);
  assign prdata   = prdata_ff;

  assign startCmd = ctrlWr && pwdata[CTRL_RUN] && pwdata[CTRL_START] &&
                    ((state_ff == ST_IDLE) || (state_ff == ST_LOW && endFlag_ff && mst_ff));
  assign stopCmd  = ctrlWr && pwdata[CTRL_STOP] && !pwdata[CTRL_START] &&
                    mst_ff && endFlag_ff && (state_ff == ST_LOW);
  assign endClr   = ctrlWr && (!pwdata[CTRL_END] || pwdata[CTRL_START] || pwdata[CTRL_STOP]);

  // ----------------------------------------------------------------
  // Arbitration checks
  // ----------------------------------------------------------------
  // start while another master's start is pending (std_ff), or while ovr_ff is set
  assign lossBusy  = startCmd && (std_ff || ovr_ff);
  assign lossEarly = (state_ff == ST_SETUP) && sdaFall && mst_ff;
  assign checkWin  = trx_ff ? (riseCnt_ff < DATA_CLKS) : (riseCnt_ff == DATA_CLKS);
  assign lossData  = mst_ff && !lost_ff && (state_ff == ST_HIGH) && sclRise &&
                     checkWin && sdaOut_ff && !sdaLine;
  assign anyLoss   = lossBusy || lossEarly || lossData;

  // byte end at last clock fall
  assign lastClk   = eightClk_ff ? DATA_CLKS : ACK_CLK;
  assign byteEnd   = sclFall && (riseCnt_ff == lastClk);
  assign endSet    = byteEnd && (mst_ff || slave_ff);

  // ----------------------------------------------------------------
  // Bus clock counter and receive shifter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      riseCnt_ff <= 4'h0;
    end else if (startDet || byteEnd || (state_ff == ST_SHOLD)) begin
      riseCnt_ff <= 4'h0;
    end else if (sclRise && riseCnt_ff < ACK_CLK) begin
      riseCnt_ff <= riseCnt_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxShift_ff <= 8'h00;
      rxData_ff  <= 8'h00;
      rxFull_ff  <= 1'b0;
      ovr_ff     <= 1'b0;
    end else begin
      if (sclRise && riseCnt_ff < DATA_CLKS) begin
        rxShift_ff <= {rxShift_ff[6:0], sdaLine};
      end
      if (rdAcc && paddr == DATA_OFS) begin
        rxFull_ff <= 1'b0;
      end
      if (statWr && pwdata[STAT_OVR]) begin
        ovr_ff <= 1'b0;
      end
      if (endSet) begin
        rxData_ff <= rxShift_ff;
        rxFull_ff <= 1'b1;
        if (rxFull_ff) begin
          ovr_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus observation flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      std_ff  <= 1'b0;
    end else begin
      if (stopDet) begin
        busy_ff <= 1'b0;
        std_ff  <= 1'b0;
      end
      if (statWr && pwdata[STAT_STD]) begin
        std_ff <= 1'b0;
      end
      if (startDet) begin
        busy_ff <= 1'b1;
        if (!mst_ff) begin
          std_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Software control fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      run_ff      <= 1'b0;
      eightClk_ff <= 1'b0;
      ackBit_ff   <= 1'b0;
      txData_ff   <= 8'h00;
    end else begin
      if (ctrlWr) begin
        run_ff      <= pwdata[CTRL_RUN];
        eightClk_ff <= pwdata[CTRL_EIGHT];
        ackBit_ff   <= pwdata[CTRL_ACK];
      end
      if (wrAcc && paddr == DATA_OFS) begin
        txData_ff <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte-end flag
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      endFlag_ff <= 1'b0;
    end else if (endSet) begin
      endFlag_ff <= 1'b1;
    end else if (endClr) begin
      endFlag_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Role and direction flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mst_ff       <= 1'b0;
      trx_ff       <= 1'b0;
      slave_ff     <= 1'b0;
      lost_ff      <= 1'b0;
      firstByte_ff <= 1'b0;
      txShift_ff   <= 8'h00;
    end else begin
      if (stopDet && !mst_ff) begin
        slave_ff <= 1'b0;
      end
      if (ctrlWr && endFlag_ff && !pwdata[CTRL_END]) begin
        txShift_ff <= txData_ff;
      end
      if (byteEnd && mst_ff) begin
        firstByte_ff <= 1'b0;
        if (firstByte_ff && !lost_ff) begin
          trx_ff <= ~txShift_ff[0];
        end
      end
      if (endSet && lost_ff) begin
        mst_ff   <= 1'b0;
        lost_ff  <= 1'b0;
        slave_ff <= 1'b1;
      end
      if (state_ff == ST_PREL && timerDone) begin
        mst_ff <= 1'b0;
      end
      if (startCmd) begin
        mst_ff       <= 1'b1;
        trx_ff       <= 1'b1;
        lost_ff      <= 1'b0;
        slave_ff     <= 1'b0;
        firstByte_ff <= 1'b1;
        txShift_ff   <= txData_ff;
      end
      if (lossEarly || lossData) begin
        trx_ff  <= 1'b0;
        lost_ff <= 1'b1;
      end
      if (lossBusy) begin
        mst_ff   <= 1'b0;
        trx_ff   <= 1'b0;
        slave_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      al_ff <= 1'b0;
    end else if (anyLoss) begin
      al_ff <= 1'b1;
    end else if (startCmd || (statWr && pwdata[STAT_AL])) begin
      al_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Master clock generator
  // ----------------------------------------------------------------
  assign timerDone = (halfCnt_ff == 16'(HALF_CYC - 1));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (startCmd && !lossBusy) begin
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (!mst_ff) begin
          nxt_state = ST_IDLE;
        end else if (lossEarly) begin
          nxt_state = ST_LOW;
        end else if (timerDone) begin
          nxt_state = ST_SHOLD;
        end
      end
      ST_SHOLD: begin
        if (timerDone) begin
          nxt_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (!mst_ff) begin
          nxt_state = ST_IDLE;
        end else if (stopCmd) begin
          nxt_state = ST_PLOW;
        end else if (startCmd && !lossBusy) begin
          nxt_state = ST_SETUP;
        end else if (timerDone && !endFlag_ff) begin
          nxt_state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (timerDone) begin
          nxt_state = ST_LOW;
        end
      end
      ST_PLOW: begin
        if (timerDone) begin
          nxt_state = ST_PHIGH;
        end
      end
      ST_PHIGH: begin
        if (timerDone) begin
          nxt_state = ST_PREL;
        end
      end
      ST_PREL: begin
        if (timerDone) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // High phase waits for the line, so a stretching slave pauses it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      halfCnt_ff <= 16'h0000;
    end else if (nxt_state != state_ff || timerDone) begin
      halfCnt_ff <= 16'h0000;
    end else if (state_ff != ST_HIGH || sclLine) begin
      halfCnt_ff <= halfCnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // SDA drive value
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sdaOut = sdaOut_ff;
    case (state_ff)
      ST_IDLE:  nxt_sdaOut = 1'b1;
      ST_SETUP: nxt_sdaOut = 1'b1;
      ST_SHOLD: nxt_sdaOut = 1'b0;
      ST_LOW:   nxt_sdaOut = bitToSend(riseCnt_ff, trx_ff, txShift_ff, ackBit_ff);
      ST_HIGH:  nxt_sdaOut = sdaOut_ff;
      ST_PLOW:  nxt_sdaOut = 1'b0;
      ST_PHIGH: nxt_sdaOut = 1'b0;
      ST_PREL:  nxt_sdaOut = 1'b1;
      default:  nxt_sdaOut = 1'b1;
    endcase
    if (lost_ff || anyLoss || !mst_ff) begin
      nxt_sdaOut = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sdaOut_ff <= 1'b1;
    end else begin
      sdaOut_ff <= nxt_sdaOut;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, open drain
  // ----------------------------------------------------------------
  assign sclOut  = 1'b0;
  assign sdaOut  = 1'b0;
  assign sdaOe_n = sdaOut_ff;
  assign sclOe_n = ~(endFlag_ff || state_ff == ST_LOW || state_ff == ST_PLOW);

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irqEvents = {stopDet, anyLoss, endSet};
  assign irq       = |(irqStat_ff & irqMask_ff);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irqStat_ff <= '0;
      irqMask_ff <= IRQ_MASK_RST;
    end else begin
      if (rdAcc && paddr == IRQ_STAT_OFS) begin
        irqStat_ff <= (irqStat_ff & ~irqSnap_ff) | irqEvents;
      end else begin
        irqStat_ff <= irqStat_ff | irqEvents;
      end
      if (wrAcc && paddr == IRQ_MASK_OFS) begin
        irqMask_ff <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prdata_ff  <= 32'h0000_0000;
      irqSnap_ff <= '0;
    end else if (setupPh && !pwrite) begin
      prdata_ff  <= 32'h0000_0000;
      irqSnap_ff <= '0;
      case (paddr)
        CTRL_OFS: begin
          prdata_ff[CTRL_RUN]   <= run_ff;
          prdata_ff[CTRL_EIGHT] <= eightClk_ff;
          prdata_ff[CTRL_ACK]   <= ackBit_ff;
          prdata_ff[CTRL_BUSY]  <= busy_ff;
          prdata_ff[CTRL_END]   <= endFlag_ff;
        end
        STAT_OFS: begin
          prdata_ff[STAT_MST] <= mst_ff;
          prdata_ff[STAT_TRX] <= trx_ff;
          prdata_ff[STAT_OVR] <= ovr_ff;
          prdata_ff[STAT_AL]  <= al_ff;
          prdata_ff[STAT_SLV] <= slave_ff;
          prdata_ff[STAT_STD] <= std_ff;
        end
        DATA_OFS:     prdata_ff[7:0] <= rxData_ff;
        IRQ_STAT_OFS: begin
          prdata_ff[IRQ_W-1:0] <= irqStat_ff;
          irqSnap_ff           <= irqStat_ff;
        end
        IRQ_MASK_OFS: prdata_ff[IRQ_W-1:0] <= irqMask_ff;
        default:      prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

endmodule : i2c_arbitration_loss
`default_nettype wire

// File: i2c_arb_pkg.sv
`default_nettype none
package i2c_arb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] DATA_OFS     = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

  // ----------------------------------------------------------------
  // bus_control_register fields
  // ----------------------------------------------------------------
  localparam int CTRL_RUN   = 7;
  localparam int CTRL_START = 6;
  localparam int CTRL_STOP  = 5;
  localparam int CTRL_EIGHT = 4;
  localparam int CTRL_ACK   = 3;
  localparam int CTRL_BUSY  = 2;
  localparam int CTRL_END   = 1;

  // ----------------------------------------------------------------
  // bus_status_register fields
  // ----------------------------------------------------------------
  localparam int STAT_MST = 0;
  localparam int STAT_TRX = 1;
  localparam int STAT_OVR = 2;
  localparam int STAT_AL  = 3;
  localparam int STAT_SLV = 4;
  localparam int STAT_STD = 5;

  // ----------------------------------------------------------------
  // Interrupt status and mask fields
  // ----------------------------------------------------------------
  localparam int         IRQ_W        = 3;
  localparam int         IRQ_END      = 0;
  localparam int         IRQ_AL       = 1;
  localparam int         IRQ_STOP     = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Byte framing and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] DATA_CLKS    = 4'h8;
  localparam logic [3:0] ACK_CLK      = 4'h9;
  localparam int         CORE_MHZ     = 200;
  localparam int         SCL_HALF_NS  = 5000;
  localparam int         SCL_HALF_CYC = (SCL_HALF_NS * CORE_MHZ + 999) / 1000;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SETUP = 8'h02,
    ST_SHOLD = 8'h04,
    ST_LOW   = 8'h08,
    ST_HIGH  = 8'h10,
    ST_PLOW  = 8'h20,
    ST_PHIGH = 8'h40,
    ST_PREL  = 8'h80
  } master_state_t;

endpackage : i2c_arb_pkg
`default_nettype wire

// File: arb_line_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module arb_line_monitor (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Raw bus pins
  input  wire logic sclPin,
  input  wire logic sdaPin,
  // Synchronised levels and events
  output logic      sclLine,
  output logic      sdaLine,
  output logic      sclRise,
  output logic      sclFall,
  output logic      sdaFall,
  output logic      startDet,
  output logic      stopDet
);

  // ----------------------------------------------------------------
  // Two-flop synchronisers plus one history stage
  // ----------------------------------------------------------------
  logic [2:0] sclSync_ff;
  logic [2:0] sdaSync_ff;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclSync_ff <= 3'h7;
      sdaSync_ff <= 3'h7;
    end else begin
      sclSync_ff <= {sclSync_ff[1:0], sclPin};
      sdaSync_ff <= {sdaSync_ff[1:0], sdaPin};
    end
  end

  // ----------------------------------------------------------------
  // Edge and condition decode, never from the first stage
  // ----------------------------------------------------------------
  assign sclLine  = sclSync_ff[1];
  assign sdaLine  = sdaSync_ff[1];
  assign sclRise  = sclSync_ff[1] & ~sclSync_ff[2];
  assign sclFall  = ~sclSync_ff[1] & sclSync_ff[2];
  assign sdaFall  = ~sdaSync_ff[1] & sdaSync_ff[2];
  assign startDet = sdaFall & sclSync_ff[1] & sclSync_ff[2];
  assign stopDet  = sdaSync_ff[1] & ~sdaSync_ff[2] & sclSync_ff[1] & sclSync_ff[2];

endmodule : arb_line_monitor
`default_nettype wire

// File: i2c_arb_properties.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_arb_properties (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sclOut,
  input wire logic        sclOe_n,
  input wire logic        sdaOut,
  input wire logic        sdaOe_n,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_sdaOut; sdaOut == 1'b0; endproperty
  a_sdaOut: assert property (p_sdaOut) else $error("sda drives high");
  property p_sclOut; sclOut == 1'b0; endproperty
  a_sclOut: assert property (p_sclOut) else $error("scl drives high");
  property p_relRst; $rose(reset_n) |-> sdaOe_n && sclOe_n && !irq; endproperty
  a_relRst: assert property (p_relRst) else $error("bus held after reset");
  property p_errAcc; pslverr |-> psel && penable; endproperty
  a_errAcc: assert property (p_errAcc) else $error("error outside access");
  property p_rdyAcc; psel && penable |-> pready; endproperty
  a_rdyAcc: assert property (p_rdyAcc) else $error("access not ready");
  property p_errData; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_errData: assert property (p_errData) else $error("refused read data");
  property p_sclLow; $fell(sclOe_n) |=> !sclOe_n [*3]; endproperty
  a_sclLow: assert property (p_sclLow) else $error("scl low half short");
  property p_sclHigh; $rose(sclOe_n) |=> sclOe_n [*3]; endproperty
  a_sclHigh: assert property (p_sclHigh) else $error("scl high half short");
endmodule : i2c_arb_properties
bind i2c_arbitration_loss i2c_arb_properties chk (.core_clk, .reset_n, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .sclOut, .sclOe_n, .sdaOut, .sdaOe_n, .irq);
`default_nettype wire

// File: i2c_bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_partner (
  input wire logic       core_clk,
  input wire logic       sclLine,
  input wire logic       compete,
  input wire logic       holdLow,
  input wire logic [7:0] byteVal,
  output logic           sdaPull_n
);
  logic       sclPrev;
  logic [3:0] fallCnt;
  always_ff @(posedge core_clk) begin
    sclPrev <= sclLine;
    if (!compete) fallCnt <= 4'h0;
    else if (sclPrev && !sclLine && fallCnt < 4'hF) fallCnt <= fallCnt + 4'h1;
  end
  always_comb begin
    sdaPull_n = !holdLow;
    if (fallCnt >= 4'h1 && fallCnt <= 4'h8) sdaPull_n = sdaPull_n & byteVal[4'h8 - fallCnt];
  end
endmodule : i2c_bus_partner
`default_nettype wire

// File: i2c_arbitration_loss_test.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_arbitration_loss_test;
  import i2c_arb_pkg::*;
  logic        core_clk, reset_n, psel, penable, pwrite, compete, holdLow;
  logic [7:0]  paddr, byteVal;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, sclOut, sclOe_n, sdaOut, sdaOe_n, irq, sdaPull_n, e;
  int          miscompares, comparisons, cycles, n;
  wire logic   sdaLine = sdaOe_n & sdaPull_n;
  i2c_arbitration_loss #(.HALF_CYC(8)) uut (.core_clk, .reset_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .sclIn(sclOe_n), .sclOut, .sclOe_n,
    .sdaIn(sdaLine), .sdaOut, .sdaOe_n, .irq);
  i2c_bus_partner partner (.core_clk, .sclLine(sclOe_n), .compete, .holdLow, .byteVal,
    .sdaPull_n);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      stop_test();
    end
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task stop_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdChk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(a, 1'b0, 32'h0);
    chk(name, q, exp);
  endtask : rdChk
  task doReset();
    @(posedge core_clk);
    reset_n <= 1'b0; compete <= 1'b0; holdLow <= 1'b0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask : doReset
  task waitEnd();
    n = 0;
    do begin
      apb(CTRL_OFS, 1'b0, 32'h0);
      n++;
    end while (q[CTRL_END] !== 1'b1 && n < 400);
  endtask : waitEnd
  task testRegs();
    rdChk(STAT_OFS, 32'h0, "status reset");
    rdChk(IRQ_MASK_OFS, {29'h0, IRQ_MASK_RST}, "mask reset");
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", q, 32'h0);
  endtask : testRegs
  task testDataLoss();
    byteVal <= 8'h50; compete <= 1'b1;
    apb(IRQ_MASK_OFS, 1'b1, 32'h7);
    apb(DATA_OFS, 1'b1, 32'h58);
    apb(CTRL_OFS, 1'b1, 32'hC0);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    rdChk(STAT_OFS, 32'h09, "status at loss");
    chk("sda released", sdaOe_n, 1'b1);
    waitEnd();
    rdChk(STAT_OFS, 32'h18, "status at end");
    chk("nine clocks", partner.fallCnt, 4'hA);
    chk("scl held", sclOe_n, 1'b0);
    rdChk(IRQ_STAT_OFS, 32'h3, "irq events");
    @(posedge core_clk);
    @(posedge core_clk);
    chk("irq cleared", irq, 1'b0);
  endtask : testDataLoss
  task testRefused();
    holdLow <= 1'b1;
    repeat (8) @(posedge core_clk);
    apb(CTRL_OFS, 1'b1, 32'hC0);
    rdChk(STAT_OFS, 32'h38, "refused start");
    holdLow <= 1'b0;
    repeat (8) @(posedge core_clk);
    rdChk(STAT_OFS, 32'h08, "after stop");
  endtask : testRefused
  task testEarly();
    byteVal <= 8'hFF; compete <= 1'b1;
    apb(CTRL_OFS, 1'b1, 32'hD0);
    holdLow <= 1'b1;
    n = 0;
    while (sclOe_n !== 1'b0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    holdLow <= 1'b0;
    rdChk(STAT_OFS, 32'h09, "early fall");
    waitEnd();
    rdChk(STAT_OFS, 32'h18, "early end");
    chk("eight clocks", partner.fallCnt, 4'h9);
  endtask : testEarly
  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; compete = 1'b0; holdLow = 1'b0; byteVal = 8'hFF;
    miscompares = 0; comparisons = 0; cycles = 0;
    doReset();
    testRegs();
    testDataLoss();
    doReset();
    testRefused();
    doReset();
    testEarly();
    stop_test();
  end
endmodule : i2c_arbitration_loss_test
`default_nettype wire
